//--- verif/serial_status_flag_logic_tb.sv
// Self-checking bench for the serial status flag logic
`timescale 1ns/100ps
module serial_status_flag_logic_tb;
  // Small FIFO so that a few frames fill it
  localparam int unsigned DEPTH = 2;
  localparam int MAX_CYCLES = 5000;
  localparam logic [2:0] A_MD = ssf_pkg::ADDR_MODE;
  localparam logic [2:0] A_CT = ssf_pkg::ADDR_CTRL;
  localparam logic [2:0] A_TX = ssf_pkg::ADDR_TXD;
  localparam logic [2:0] A_ST = ssf_pkg::ADDR_STAT;
  localparam logic [2:0] A_RX = ssf_pkg::ADDR_RXD;
  // Frames: stop, mp bit, parity, data
  localparam logic [10:0] F1 = 11'h603;
  localparam logic [10:0] F2 = 11'h001;
  localparam logic [10:0] F3 = 11'h601;
  localparam logic [10:0] F4 = 11'h6ff;
  logic clock;
  logic rst_b;
  logic [ssf_pkg::ADDR_W-1:0] reg_addr;
  logic [ssf_pkg::REG_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [ssf_pkg::REG_W-1:0] reg_rdata;
  logic tx_load;
  logic tx_last_bit;
  logic [ssf_pkg::DATA_W-1:0] tx_data;
  logic tx_mp_bit;
  logic tx_enable;
  logic rx_frame_valid;
  logic [ssf_pkg::FRAME_W-1:0] rx_frame;
  logic rx_frame_ready;
  int mismatches;
  int cmp_count;
  int cycles;

  ssf_top #(.RX_FIFO_DEPTH(DEPTH)) DUT (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_load(tx_load), .tx_last_bit(tx_last_bit), .tx_data(tx_data), .tx_mp_bit(tx_mp_bit),
    .tx_enable(tx_enable), .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame),
    .rx_frame_ready(rx_frame_ready));

  ssf_serial_partner PART (.clock(clock), .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame),
    .tx_load(tx_load), .tx_last_bit(tx_last_bit));

  // 50 MHz clock
  always #10 clock = ~clock;

  // Hang guard, far above the roughly 120 cycles the tests need
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      mismatches++;
      stop_test();
    end
  end

  // Expected status after a frame: full, framing, parity, mp bit
  function automatic logic [7:0] rx_flags(input logic [10:0] f, input logic odd);
    rx_flags = {1'b0, 1'b1, 1'b0, ~f[10], ^f[8:0] ^ odd, 1'b0, f[9], 1'b0};
  endfunction

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected bit at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Write strobe for one cycle, then one idle cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    cmp8(reg_rdata, exp);
    @(posedge clock);
    #1;
  endtask

  // Read the status, then write zero to clear what was seen set
  task automatic clr(input logic [7:0] exp);
    rd(A_ST, exp);
    wr(A_ST, 8'h00);
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    #1;
    rd(A_ST, ssf_pkg::STAT_RESET);
    rd(3'h7, 8'h00);
    wr(3'h7, 8'hff);
    rd(A_ST, ssf_pkg::STAT_RESET);
    done("reset");
    wr(A_ST, 8'h81);
    cmp1(tx_mp_bit, 1'b1);
    rd(A_ST, 8'h85);
    wr(A_ST, 8'hf8);
    cmp1(tx_mp_bit, 1'b0);
    rd(A_ST, 8'h84);
    done("mp_send");
    wr(A_TX, 8'h5a);
    cmp8(tx_data, 8'h5a);
    rd(A_ST, 8'h00);
    PART.pulse_last();
    rd(A_ST, 8'h00);
    PART.pulse_load();
    rd(A_ST, 8'h80);
    PART.pulse_last();
    clr(8'h84);
    rd(A_ST, 8'h00);
    done("tx_end");
    PART.pulse_load();
    rd(A_ST, 8'h80);
    wr(A_ST, 8'hf8);
    rd(A_ST, 8'h80);
    wr(A_CT, 8'h20);
    cmp1(tx_enable, 1'b1);
    rd(A_ST, 8'h80);
    wr(A_CT, 8'h00);
    cmp1(tx_enable, 1'b0);
    clr(8'h84);
    done("tx_enable");
    // Four frames into a two-deep FIFO while the first is held: the last overruns
    PART.send_frame(F1, 4);
    PART.send_frame(F2, 4);
    PART.send_frame(F3, 4);
    PART.send_frame(F4, 4);
    cmp1(rx_frame_ready, 1'b0);
    rd(A_RX, F1[7:0]);
    clr(rx_flags(F1, 1'b0) | 8'h20);
    repeat (4) @(posedge clock);
    #1;
    wr(A_ST, 8'h00);
    rd(A_ST, rx_flags(F2, 1'b0));
    rd(A_RX, F2[7:0]);
    wr(A_MD, 8'h10);
    wr(A_ST, 8'h00);
    repeat (4) @(posedge clock);
    #1;
    rd(A_ST, rx_flags(F3, 1'b1));
    rd(A_RX, F3[7:0]);
    cmp1(rx_frame_ready, 1'b1);
    done("receive");
    stop_test();
  end
endmodule

//--- verif/ssf_serial_partner.sv
// Far-side model: remote character source and transmit shifter pulses
`timescale 1ns/100ps
module ssf_serial_partner (
  // Clock
  input wire logic clock,
  // Receive shifter side
  output logic rx_frame_valid,
  output logic [ssf_pkg::FRAME_W-1:0] rx_frame,
  // Transmit shifter side
  output logic tx_load,
  output logic tx_last_bit
);
  // Quiet line at time zero
  initial begin
    rx_frame_valid = 1'b0;
    rx_frame = 11'h000;
    tx_load = 1'b0;
    tx_last_bit = 1'b0;
  end

  // One frame per character time; a remote sender cannot wait, so ready is not honoured
  task automatic send_frame(input logic [ssf_pkg::FRAME_W-1:0] f, input int gap);
    rx_frame_valid <= 1'b1;
    rx_frame <= f;
    @(posedge clock);
    rx_frame_valid <= 1'b0;
    // Idle bus shows no stale copy of the frame
    rx_frame <= ~f;
    repeat (gap) @(posedge clock);
  endtask

  // Shifter took the transmit data
  task automatic pulse_load();
    tx_load <= 1'b1;
    @(posedge clock);
    tx_load <= 1'b0;
    @(posedge clock);
  endtask

  // Last bit of a character left the shifter
  task automatic pulse_last();
    tx_last_bit <= 1'b1;
    @(posedge clock);
    tx_last_bit <= 1'b0;
    @(posedge clock);
  endtask
endmodule

//--- verilog/ssf_fifo.sv
// Receive frame FIFO with registered ready
`timescale 1ns/100ps
module ssf_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Fill and drain sides
  ssf_stream_if.snk fill,
  ssf_stream_if.src drain
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = PW + 1;

  // Pointer arithmetic wraps, so only powers of two work
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("ssf_fifo depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wptr_ff;
  logic [PW-1:0] rptr_ff;
  logic [CW-1:0] count_ff;
  logic not_full_ff;
  wire push;
  wire pop;
  wire [CW-1:0] nxt_count;

  // Handshakes and occupancy
  assign push = fill.valid & fill.ready;
  assign pop = drain.valid & drain.ready;
  assign nxt_count = count_ff + CW'(push) - CW'(pop);
  assign fill.ready = not_full_ff; // Registered, so the source sees a clean level
  assign drain.valid = (count_ff != '0);
  assign drain.data = mem[rptr_ff];

  // Storage has no reset; only pointers, count and full flag are control state
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wptr_ff] <= fill.data;
    end
  end

  // Pointers and flags
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
      not_full_ff <= 1'b1;
    end else begin
      wptr_ff <= wptr_ff + PW'(push);
      rptr_ff <= rptr_ff + PW'(pop);
      count_ff <= nxt_count;
      not_full_ff <= (nxt_count != CW'(DEPTH));
    end
  end
endmodule

//--- verilog/ssf_pkg.sv
// Constants shared by the serial status flag logic
package ssf_pkg;
  // Frame word from the receive shifter: stop, mp bit, parity, data
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FRAME_W = 11;
  localparam int unsigned FR_PAR_POS = 8;
  localparam int unsigned FR_MP_POS = 9;
  localparam int unsigned FR_STOP_POS = 10;
  localparam logic STOP_LEVEL = 1'b1;
  localparam int unsigned FIFO_DEPTH = 8;

  // Register port
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned REG_W = 8;
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h1;
  localparam logic [2:0] ADDR_TXD = 3'h2;
  localparam logic [2:0] ADDR_STAT = 3'h3;
  localparam logic [2:0] ADDR_RXD = 3'h4;

  // Status bit positions
  localparam int unsigned ST_TX_EMPTY = 7;
  localparam int unsigned ST_RX_FULL = 6;
  localparam int unsigned ST_OVERRUN = 5;
  localparam int unsigned ST_FRAMING = 4;
  localparam int unsigned ST_PARITY = 3;
  localparam int unsigned ST_TX_END = 2;
  localparam int unsigned ST_MP_RX = 1;
  localparam int unsigned ST_MP_TX = 0;
  localparam int unsigned ST_CLR_LO = 3;
  localparam logic [7:0] STAT_RESET = 8'h84;

  // Control and mode bits
  localparam int unsigned CTRL_TE_POS = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int unsigned MODE_PM_POS = 4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] REG_ZERO = 8'h00;
endpackage

//--- verilog/ssf_rx_check.sv
// Checks parity and stop bit of each received frame
`timescale 1ns/100ps
module ssf_rx_check (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Frames from the FIFO
  ssf_stream_if.snk frame,
  // Control
  input wire logic take_en,
  input wire logic parity_mode,
  // Result, one cycle after the frame is taken
  output logic res_valid_ff,
  output logic [ssf_pkg::DATA_W-1:0] res_data_ff,
  output logic res_mp_ff,
  output logic res_par_err_ff,
  output logic res_frm_err_ff
);
  wire take;
  wire ones_odd;

  // Hold off while a result is pending so only one frame passes per load
  assign frame.ready = take_en & ~res_valid_ff;
  assign take = frame.valid & frame.ready;
  assign ones_odd = ^frame.data[ssf_pkg::FR_PAR_POS:0];

  // Result registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      res_valid_ff <= 1'b0;
      res_data_ff <= '0;
      res_mp_ff <= 1'b0;
      res_par_err_ff <= 1'b0;
      res_frm_err_ff <= 1'b0;
    end else begin
      res_valid_ff <= take;
      if (take) begin
        res_data_ff <= frame.data[ssf_pkg::DATA_W-1:0];
        res_mp_ff <= frame.data[ssf_pkg::FR_MP_POS];
        // [R07] parity mismatch test
        res_par_err_ff <= ones_odd ^ parity_mode;
        // [R11] stop bit check
        res_frm_err_ff <= (frame.data[ssf_pkg::FR_STOP_POS] != ssf_pkg::STOP_LEVEL);
      end
    end
  end
endmodule

//--- verilog/ssf_stream_if.sv
// Valid/ready word stream between the block's own modules
`timescale 1ns/100ps
interface ssf_stream_if #(parameter int unsigned W = 11);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

//--- verilog/ssf_top.sv
// Status flag logic of the asynchronous serial interface
`timescale 1ns/100ps
// Notes on behaviour
// [R01] Transmitted multiprocessor bit equals the software mp-transmit bit.
// [R02] Each received character loads its multiprocessor bit into mp-receive status.
// [R03] Transmit-end clears when software reads buffer-empty as 1 then writes 0.
// [R04] Writing the transmit data register clears transmit-end.
// [R05] Clearing transmit-enable to 0 sets transmit-end.
// [R06] Last bit sent while buffer-empty is 1 sets transmit-end.
// [R07] Parity error sets when data plus parity mismatches selected parity mode.
// [R08] Parity error clears only by read-as-1 then write 0.
// [R09] Framing error clears only by read-as-1 then write 0.
// [R10] Writing 1 to an error or buffer flag does nothing.
// [R11] Framing error sets when the received stop bit is zero.
module ssf_top #(
  parameter int unsigned RX_FIFO_DEPTH = ssf_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire logic [ssf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ssf_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ssf_pkg::REG_W-1:0] reg_rdata,
  // Transmit shifter side
  input wire logic tx_load,
  input wire logic tx_last_bit,
  output logic [ssf_pkg::DATA_W-1:0] tx_data,
  output logic tx_mp_bit,
  output logic tx_enable,
  // Receive shifter side
  input wire logic rx_frame_valid,
  input wire logic [ssf_pkg::FRAME_W-1:0] rx_frame,
  output logic rx_frame_ready
);
  // A depth below 2, which the FIFO cannot serve, is refused here as well
  if (RX_FIFO_DEPTH < 2) begin : g_bad_depth
    $error("ssf_top receive FIFO depth must be at least 2");
  end

  // Register state
  logic [7:0] stat_ff;
  logic [7:0] nxt_stat;
  logic [7:0] armed_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] mode_ff;
  logic [7:0] txd_ff;
  logic [7:0] rxd_ff;
  logic [7:0] rdata_ff;

  // Checker results
  logic res_valid;
  logic [ssf_pkg::DATA_W-1:0] res_data;
  logic res_mp;
  logic res_par_err;
  logic res_frm_err;

  // Streams between FIFO and checker
  ssf_stream_if #(.W(ssf_pkg::FRAME_W)) rx_in ();
  ssf_stream_if #(.W(ssf_pkg::FRAME_W)) rx_out ();

  // Register access decode
  wire wr_mode = reg_wr & (reg_addr == ssf_pkg::ADDR_MODE);
  wire wr_ctrl = reg_wr & (reg_addr == ssf_pkg::ADDR_CTRL);
  wire wr_txd = reg_wr & (reg_addr == ssf_pkg::ADDR_TXD);
  wire wr_stat = reg_wr & (reg_addr == ssf_pkg::ADDR_STAT);
  wire rd_stat = reg_rd & (reg_addr == ssf_pkg::ADDR_STAT);

  // Read mux; unmapped addresses read zero
  wire [7:0] rd_mux =
    (reg_addr == ssf_pkg::ADDR_MODE) ? mode_ff :
    (reg_addr == ssf_pkg::ADDR_CTRL) ? ctrl_ff :
    (reg_addr == ssf_pkg::ADDR_TXD)  ? txd_ff :
    (reg_addr == ssf_pkg::ADDR_STAT) ? stat_ff :
    (reg_addr == ssf_pkg::ADDR_RXD)  ? rxd_ff : ssf_pkg::REG_ZERO;

  // Overrun from the link side, enable clear from a control write, buffer-empty state
  wire overrun = rx_frame_valid & ~rx_in.ready; // Frame dropped at a full FIFO
  wire te_clear = wr_ctrl & ~reg_wdata[ssf_pkg::CTRL_TE_POS];
  wire tx_buffer_empty_now = stat_ff[ssf_pkg::ST_TX_EMPTY];

  // Set events per status bit
  wire [7:0] set_ev;
  assign set_ev[ssf_pkg::ST_TX_EMPTY] = tx_load;
  assign set_ev[ssf_pkg::ST_RX_FULL] = res_valid;
  assign set_ev[ssf_pkg::ST_OVERRUN] = overrun;
  // [R11] stop bit error sets
  assign set_ev[ssf_pkg::ST_FRAMING] = res_valid & res_frm_err;
  // [R07] parity mismatch sets
  assign set_ev[ssf_pkg::ST_PARITY] = res_valid & res_par_err;
  // [R05] [R06] transmit-end set causes
  assign set_ev[ssf_pkg::ST_TX_END] = te_clear | (tx_last_bit & tx_buffer_empty_now);
  assign set_ev[ssf_pkg::ST_MP_RX] = 1'b0;
  assign set_ev[ssf_pkg::ST_MP_TX] = 1'b0;

  // Software clear: only a 0 written to a bit that was read as 1
  wire [7:0] clr_sw = {8{wr_stat}} & armed_ff & ~reg_wdata;
  wire tx_buffer_empty_sw_clr = clr_sw[ssf_pkg::ST_TX_EMPTY];

  // Clearable flags, set wins over any clear in the same cycle
  genvar gi;
  for (gi = ssf_pkg::ST_CLR_LO; gi < 8; gi++) begin : g_flag
    wire hw_clr = (gi == ssf_pkg::ST_TX_EMPTY) ? wr_txd : 1'b0;
    // [R08] [R09] [R10] clear by read-then-zero only; buffer-empty also clears on a data write
    assign nxt_stat[gi] = set_ev[gi] | (stat_ff[gi] & ~clr_sw[gi] & ~hw_clr);
  end

  // [R03] [R04] transmit-end clear causes
  wire transmit_end_flag_clr = tx_buffer_empty_sw_clr | wr_txd;
  assign nxt_stat[ssf_pkg::ST_TX_END] =
    set_ev[ssf_pkg::ST_TX_END] | (stat_ff[ssf_pkg::ST_TX_END] & ~transmit_end_flag_clr);

  // [R02] received mp bit loads
  assign nxt_stat[ssf_pkg::ST_MP_RX] = res_valid ? res_mp : stat_ff[ssf_pkg::ST_MP_RX];

  // [R01] software sets the mp bit to send
  assign nxt_stat[ssf_pkg::ST_MP_TX] = wr_stat ? reg_wdata[ssf_pkg::ST_MP_TX] : stat_ff[ssf_pkg::ST_MP_TX];

  // Status register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stat_ff <= ssf_pkg::STAT_RESET;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // Read-as-1 memory; a status write consumes it unless a status read comes in the same cycle
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      armed_ff <= ssf_pkg::REG_ZERO;
    end else if (rd_stat) begin
      armed_ff <= stat_ff;
    end else if (wr_stat) begin
      armed_ff <= ssf_pkg::REG_ZERO;
    end
  end

  // Mode and control registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_ff <= ssf_pkg::MODE_RESET;
      ctrl_ff <= ssf_pkg::CTRL_RESET;
    end else begin
      if (wr_mode) mode_ff <= reg_wdata;
      if (wr_ctrl) ctrl_ff <= reg_wdata;
    end
  end

  // Transmit and receive data registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      txd_ff <= ssf_pkg::REG_ZERO;
      rxd_ff <= ssf_pkg::REG_ZERO;
    end else begin
      if (wr_txd) txd_ff <= reg_wdata;
      if (res_valid) rxd_ff <= res_data;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= ssf_pkg::REG_ZERO;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : ssf_pkg::REG_ZERO;
    end
  end

  // Outputs, all straight from flip-flops
  assign reg_rdata = rdata_ff;
  assign tx_data = txd_ff;
  // [R01] mp bit drives the shifter
  assign tx_mp_bit = stat_ff[ssf_pkg::ST_MP_TX];
  assign tx_enable = ctrl_ff[ssf_pkg::CTRL_TE_POS];
  assign rx_frame_ready = rx_in.ready;

  // Receive path into the FIFO
  assign rx_in.valid = rx_frame_valid;
  assign rx_in.data = rx_frame;

  ssf_fifo #(
    .WIDTH(ssf_pkg::FRAME_W),
    .DEPTH(RX_FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_b(rst_b),
    .fill(rx_in),
    .drain(rx_out)
  );

  // Frames drain only while the receive buffer is free, so the FIFO can fill
  ssf_rx_check u_check (
    .clock(clock),
    .rst_b(rst_b),
    .frame(rx_out),
    .take_en(~stat_ff[ssf_pkg::ST_RX_FULL]),
    .parity_mode(mode_ff[ssf_pkg::MODE_PM_POS]),
    .res_valid_ff(res_valid),
    .res_data_ff(res_data),
    .res_mp_ff(res_mp),
    .res_par_err_ff(res_par_err),
    .res_frm_err_ff(res_frm_err)
  );

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Flag and field views for the checks, so no bit position stands bare
  wire st_transmit_end_flag = stat_ff[ssf_pkg::ST_TX_END];
  wire st_ovr = stat_ff[ssf_pkg::ST_OVERRUN];
  wire st_fer = stat_ff[ssf_pkg::ST_FRAMING];
  wire st_par = stat_ff[ssf_pkg::ST_PARITY];
  wire st_mp_rx = stat_ff[ssf_pkg::ST_MP_RX];
  wire wd_tx_buffer_empty = reg_wdata[ssf_pkg::ST_TX_EMPTY];
  wire wd_fer = reg_wdata[ssf_pkg::ST_FRAMING];
  wire wd_par = reg_wdata[ssf_pkg::ST_PARITY];
  wire pm_odd = mode_ff[ssf_pkg::MODE_PM_POS];
  wire take_now = rx_out.valid & rx_out.ready;
  wire [ssf_pkg::FRAME_W-1:0] take_frame = rx_out.data;
  // Clearable flags and the matching write bits
  wire [ssf_pkg::REG_W-ssf_pkg::ST_CLR_LO-1:0] flags_hi = stat_ff[ssf_pkg::REG_W-1:ssf_pkg::ST_CLR_LO];
  wire [ssf_pkg::REG_W-ssf_pkg::ST_CLR_LO-1:0] wdata_hi = reg_wdata[ssf_pkg::REG_W-1:ssf_pkg::ST_CLR_LO];

  // [R01] mp bit follows write
  property p_mp_tx;
    wr_stat |=> (tx_mp_bit == $past(reg_wdata[ssf_pkg::ST_MP_TX]));
  endproperty
  a_mp_tx: assert property (p_mp_tx) else $error("mp bit sent differs from written value"); // [R01]

  // [R02] received mp loads
  property p_mp_rx;
    res_valid |=> (st_mp_rx == $past(res_mp));
  endproperty
  a_mp_rx: assert property (p_mp_rx) else $error("received mp bit not loaded"); // [R02]

  // [R03] read-then-zero clears transmit-end
  sequence s_tx_buffer_empty_read_clear;
    (rd_stat && tx_buffer_empty_now) ##1 (wr_stat && !wd_tx_buffer_empty && !set_ev[ssf_pkg::ST_TX_END] && !tx_load);
  endsequence
  property p_transmit_end_flag_sw_clr;
    s_tx_buffer_empty_read_clear |=> (!st_transmit_end_flag && !tx_buffer_empty_now);
  endproperty
  a_transmit_end_flag_sw_clr: assert property (p_transmit_end_flag_sw_clr) else $error("transmit end not cleared by flag clear"); // [R03]

  // [R04] data write clears
  property p_transmit_end_flag_txd;
    (wr_txd && !set_ev[ssf_pkg::ST_TX_END]) |=> !st_transmit_end_flag;
  endproperty
  a_transmit_end_flag_txd: assert property (p_transmit_end_flag_txd) else $error("transmit end not cleared by data write"); // [R04]

  // [R05] enable clear sets
  property p_transmit_end_flag_te;
    (wr_ctrl && !reg_wdata[ssf_pkg::CTRL_TE_POS]) |=> (st_transmit_end_flag && !tx_enable);
  endproperty
  a_transmit_end_flag_te: assert property (p_transmit_end_flag_te) else $error("transmit end not set on enable clear"); // [R05]

  // [R06] last bit sets
  property p_transmit_end_flag_last;
    (tx_last_bit && tx_buffer_empty_now) |=> st_transmit_end_flag;
  endproperty
  a_transmit_end_flag_last: assert property (p_transmit_end_flag_last) else $error("transmit end not set after last bit"); // [R06]

  // [R07] parity mismatch sets
  property p_par_set;
    take_now && ((^take_frame[ssf_pkg::FR_PAR_POS:0]) != pm_odd) |-> ##2 st_par;
  endproperty
  a_par_set: assert property (p_par_set) else $error("parity error flag not set"); // [R07]

  // [R08] parity flag sticky
  property p_par_hold;
    (st_par && !(wr_stat && armed_ff[ssf_pkg::ST_PARITY] && !wd_par)) |=> st_par;
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("parity error flag dropped"); // [R08]

  // [R08] armed zero clears
  property p_par_clr;
    (wr_stat && armed_ff[ssf_pkg::ST_PARITY] && !wd_par && !set_ev[ssf_pkg::ST_PARITY]) |=> !st_par;
  endproperty
  a_par_clr: assert property (p_par_clr) else $error("parity error flag not cleared"); // [R08]

  // [R09] framing flag sticky
  property p_fer_hold;
    (st_fer && !(wr_stat && armed_ff[ssf_pkg::ST_FRAMING] && !wd_fer)) |=> st_fer;
  endproperty
  a_fer_hold: assert property (p_fer_hold) else $error("framing error flag dropped"); // [R09]

  // [R09] armed zero clears
  property p_fer_clr;
    (wr_stat && armed_ff[ssf_pkg::ST_FRAMING] && !wd_fer && !set_ev[ssf_pkg::ST_FRAMING]) |=> !st_fer;
  endproperty
  a_fer_clr: assert property (p_fer_clr) else $error("framing error flag not cleared"); // [R09]

  // [R10] ones change nothing
  property p_one_no_effect;
    (wr_stat && (&wdata_hi) && !wr_txd) |=>
      ((flags_hi & $past(flags_hi)) == $past(flags_hi));
  endproperty
  a_one_no_effect: assert property (p_one_no_effect) else $error("writing one cleared a flag"); // [R10]

  // [R11] low stop bit sets
  property p_fer_set;
    take_now && (take_frame[ssf_pkg::FR_STOP_POS] != ssf_pkg::STOP_LEVEL) |-> ##2 st_fer;
  endproperty
  a_fer_set: assert property (p_fer_set) else $error("framing error flag not set"); // [R11]

  // A frame offered at a full FIFO is lost and flagged
  property p_ovr_set;
    (rx_frame_valid && !rx_frame_ready) |=> st_ovr;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun flag not set");

  // Read data stands only after a read strobe
  property p_rdata_idle;
    !reg_rd |=> (reg_rdata == ssf_pkg::REG_ZERO);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");

  // Main scenarios
  c_full: cover property (!rx_frame_ready ##1 rx_frame_ready);
  c_par_clear: cover property (rd_stat && st_par ##1 wr_stat && !wd_par);
  c_transmit_end_flag: cover property (wr_txd ##[1:50] tx_last_bit && tx_buffer_empty_now);
  c_overrun: cover property (rx_frame_valid && !rx_frame_ready);
  c_odd_ok: cover property (res_valid && pm_odd && !res_par_err);
endmodule
